// *** hw/clfe_card_lock.sv ***
// Card-side lock command interpreter with protected-erase password and force erase.
// Assumes an APB master, a lock data link and a memory eraser on the same clock.
//
// Operation
// - With a guard password stored, every lock function is blocked until an option unlock.
// - First option unlock, locked, guard but no user password: enable and unlock.
// - First option unlock, locked, both passwords: enable functions, card stays locked.
// - Repeated option unlock with guard password: lock state kept, fail flag set.
// - Option unlock without guard password enables version 2.0 set, no error.
// - Option unlock on unlocked card holding guard password: stays unlocked, fail set.
// - Set or replace guard password keeps lock state and reports no error.
// - Clear guard function erases guard password and length, lock state kept.
// - Protected erase and clear guard unavailable without a guard password.
// - Protected erase only on locked card with both passwords, else error.
// - Undefined mode combinations fail and change no lock or password state.
// - Replace reads old and new password if one is stored, else only new.
// - Plain force erase needs a one byte block with only erase bit set.
// - Accepted force erase wipes content and user password, then unlocks.
// - Plain force erase fails on unlocked card or with guard password stored.
// - Protected erase with bits besides erase and option set is rejected.
// - Protected erase needs a matching guard password and locked card, else fails.
// - Protected erase keeps guard password and its length unchanged.
// - During erase the card stays locked and protected; unlocks after user area.
// - Permanent protect makes force erase fail; else erase, clear protects, unlock.
`timescale 1ns/1ps
`default_nettype none
module clfe_card_lock #(
  parameter int PW_BYTES = clfe_pkg::CLFE_PW_BYTES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Lock data link
  input wire logic link_clk_in,
  input wire logic link_frame_in,
  input wire logic link_data_in,
  // Memory eraser
  output logic erase_req_out,
  input wire logic erase_done_in,
  // Card state and user-function hand-off
  output logic card_locked_out,
  output logic lock_fail_flag_out,
  output logic plain_cmd_valid_out,
  output logic [7:0] plain_cmd_mode_out
);
  import clfe_pkg::*;

  localparam int BUF_BYTES = CLFE_POS_PASSWORD + 2 * PW_BYTES;
  localparam int CW = $clog2(BUF_BYTES + 1);
  localparam int LW = $clog2(PW_BYTES + 1);

  typedef enum logic {CLFE_IDLE, CLFE_ERASING} clfe_state_e;

  // Lock, protects and lengths clear on reset; software restores all but the guard password length
  typedef struct packed {
    clfe_state_e st;
    logic locked;
    logic permanent_write_protect;
    logic temporary_write_protect;
    logic group_write_protect;
    logic [LW-1:0] user_password_length;
    logic [LW-1:0] erase_guard_password_length;
    logic [PW_BYTES-1:0][7:0] erase_guard_password;
    logic unlock_seen;
    logic v2_en;
    logic fail;
    logic [BUF_BYTES-1:0][7:0] blk;
    logic [CW-1:0] cnt;
    logic ovf;
    logic [7:0] last_mode;
    logic [31:0] rdata;
    logic plain_valid;
  } clfe_state_s;

  clfe_state_s r_reg;
  clfe_state_s r_next;
  clfe_byte_s rx_byte;
  clfe_frame_s rx_frame;

  clfe_link_rx u_link_rx (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .link_clk_in(link_clk_in),
    .link_frame_in(link_frame_in),
    .link_data_in(link_data_in),
    .byte_out(rx_byte),
    .frame_out(rx_frame)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic pw_match(input logic [BUF_BYTES-1:0][7:0] b, input int base,
                                    input logic [PW_BYTES-1:0][7:0] pw,
                                    input logic [LW-1:0] len);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < PW_BYTES; i++) begin
      if (i < int'(len) && b[base + i] != pw[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : pw_match

  function automatic logic addr_known(input logic [7:0] a);
    return a == CLFE_OFS_CTRL || a == CLFE_OFS_USER_LEN || a == CLFE_OFS_STATUS ||
           a == CLFE_OFS_LAST_MODE;
  endfunction : addr_known

  // A stored guard password shuts every lock function until the unlock
  function automatic logic gated(input logic guard, input logic seen);
    return guard && !seen;
  endfunction : gated

  // Overflowed, or shorter than its own size byte claims
  function automatic logic blk_bad(input logic ovf, input logic [CW-1:0] cnt,
                                   input logic [7:0] size);
    return ovf || int'(cnt) < CLFE_POS_PASSWORD + int'(size);
  endfunction : blk_bad

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [7:0] mode;
    logic [7:0] size;
    logic [7:0] new_len;
    logic guard;
    logic fail;
    logic start_erase;
    int base;
    mode = r_reg.blk[CLFE_POS_MODE];
    size = r_reg.blk[CLFE_POS_SIZE];
    new_len = 8'h00;
    guard = r_reg.erase_guard_password_length != '0;
    fail = 1'b0;
    start_erase = 1'b0;
    base = CLFE_POS_PASSWORD;
    r_next = r_reg;
    r_next.plain_valid = 1'b0;

    // APB: read data captured in setup so the access phase answers at once
    if (psel_in && !penable_in) begin
      r_next.rdata = 32'h0000_0000;
      unique case (paddr_in)
        CLFE_OFS_CTRL: begin
          r_next.rdata[CLFE_CTRL_LOCKED] = r_reg.locked;
          r_next.rdata[CLFE_CTRL_PERM_PROT] = r_reg.permanent_write_protect;
          r_next.rdata[CLFE_CTRL_TEMP_PROT] = r_reg.temporary_write_protect;
          r_next.rdata[CLFE_CTRL_GROUP_PROT] = r_reg.group_write_protect;
        end
        CLFE_OFS_USER_LEN: r_next.rdata[LW-1:0] = r_reg.user_password_length;
        CLFE_OFS_STATUS: begin
          r_next.rdata[CLFE_ST_LOCKED] = r_reg.locked;
          r_next.rdata[CLFE_ST_FAIL] = r_reg.fail;
          r_next.rdata[CLFE_ST_UNLOCK_SEEN] = r_reg.unlock_seen;
          r_next.rdata[CLFE_ST_V2_EN] = r_reg.v2_en;
          r_next.rdata[CLFE_ST_ERASING] = r_reg.st == CLFE_ERASING;
          r_next.rdata[CLFE_ST_GUARD] = guard;
          r_next.rdata[CLFE_ST_GLEN_LSB +: LW] = r_reg.erase_guard_password_length;
        end
        CLFE_OFS_LAST_MODE: r_next.rdata[7:0] = r_reg.last_mode;
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    // Software mirror of non-volatile lock state; blocked while erasing
    if (psel_in && penable_in && pwrite_in && r_reg.st == CLFE_IDLE) begin
      if (paddr_in == CLFE_OFS_CTRL) begin
        r_next.locked = pwdata_in[CLFE_CTRL_LOCKED];
        r_next.permanent_write_protect = pwdata_in[CLFE_CTRL_PERM_PROT];
        r_next.temporary_write_protect = pwdata_in[CLFE_CTRL_TEMP_PROT];
        r_next.group_write_protect = pwdata_in[CLFE_CTRL_GROUP_PROT];
        if (pwdata_in[CLFE_CTRL_SOFT_RST]) begin
          r_next.unlock_seen = 1'b0;
          r_next.v2_en = 1'b0;
        end
      end else if (paddr_in == CLFE_OFS_USER_LEN) begin
        r_next.user_password_length = pwdata_in[LW-1:0];
      end
    end

    // Collect the data block
    // Bytes beyond the buffer only mark overflow; force erase, set guard and protected erase then fail
    if (rx_frame.start) begin
      r_next.cnt = '0;
      r_next.ovf = 1'b0;
    end else if (rx_byte.valid) begin
      if (int'(r_reg.cnt) < BUF_BYTES) begin
        r_next.blk[r_reg.cnt] = rx_byte.data;
        r_next.cnt = r_reg.cnt + CW'(1);
      end else begin
        r_next.ovf = 1'b1;
      end
    end

    // Frames arriving mid-erase are ignored: the card is busy
    if (rx_frame.stop && r_reg.st == CLFE_IDLE && r_reg.cnt != '0) begin
      r_next.last_mode = mode;
      if (!mode[CLFE_MODE_OPTION_BIT]) begin
        if (gated(guard, r_reg.unlock_seen)) begin
          fail = 1'b1;
        end else if (mode[CLFE_MODE_ERASE_BIT]) begin
          if (mode != CLFE_MODE_FORCE_ERASE || r_reg.ovf ||
              int'(r_reg.cnt) != CLFE_PLAIN_ERASE_BYTES) begin
            fail = 1'b1;
          end else if (guard || !r_reg.locked) begin
            fail = 1'b1;
          end else begin
            start_erase = 1'b1;
          end
        end else begin
          // User password functions are served outside this block
          r_next.plain_valid = 1'b1;
        end
      end else if (mode == CLFE_MODE_OPTION_UNLOCK) begin
        // Any unlock counts, so one sent before the guard existed is the first
        r_next.unlock_seen = 1'b1;
        if (!guard) begin
          r_next.v2_en = 1'b1;
        end else if (r_reg.locked && !r_reg.unlock_seen) begin
          r_next.v2_en = 1'b1;
          if (r_reg.user_password_length == '0) begin
            r_next.locked = 1'b0;
          end
          // With a user password the card stays locked here
        end else begin
          // Unlocked or repeated unlock: state kept
          fail = 1'b1;
        end
      end else if (gated(guard, r_reg.unlock_seen)) begin
        fail = 1'b1;
      end else begin
        unique case (mode)
          CLFE_MODE_SET_GUARD: begin
            // Old password precedes the new one only when one is stored
            if (guard) begin
              base = CLFE_POS_PASSWORD + int'(r_reg.erase_guard_password_length);
              new_len = size - 8'(r_reg.erase_guard_password_length);
            end else begin
              new_len = size;
            end
            if (blk_bad(r_reg.ovf, r_reg.cnt, size) ||
                new_len == 8'h00 || int'(new_len) > PW_BYTES ||
                !pw_match(r_reg.blk, CLFE_POS_PASSWORD, r_reg.erase_guard_password,
                          r_reg.erase_guard_password_length)) begin
              fail = 1'b1;
            end else begin
              r_next.erase_guard_password_length = LW'(new_len);
              for (int i = 0; i < PW_BYTES; i++) begin
                r_next.erase_guard_password[i] =
                  (i < int'(new_len)) ? r_reg.blk[base + i] : 8'h00;
              end
            end
          end
          CLFE_MODE_CLR_GUARD: begin
            if (!guard) begin
              fail = 1'b1;
            end else begin
              r_next.erase_guard_password_length = '0;
              r_next.erase_guard_password = '0;
            end
          end
          CLFE_MODE_PROT_ERASE: begin
            if (!guard) begin
              fail = 1'b1;
            end else if (!r_reg.locked || r_reg.user_password_length == '0) begin
              fail = 1'b1;
            end else if (blk_bad(r_reg.ovf, r_reg.cnt, size) ||
                         size != 8'(r_reg.erase_guard_password_length) ||
                         !pw_match(r_reg.blk, CLFE_POS_PASSWORD, r_reg.erase_guard_password,
                                   r_reg.erase_guard_password_length)) begin
              fail = 1'b1;
            end else begin
              start_erase = 1'b1;
            end
          end
          default: fail = 1'b1;
        endcase
      end
      // Permanent protect wins over any erase request
      if (start_erase) begin
        if (r_reg.permanent_write_protect) begin
          fail = 1'b1;
        end else begin
          r_next.st = CLFE_ERASING;
        end
      end
      // Fail flag shows the outcome of the latest lock command
      r_next.fail = fail;
    end

    // Lock and protects change only once the user area is gone
    if (r_reg.st == CLFE_ERASING && erase_done_in) begin
      r_next.st = CLFE_IDLE;
      r_next.locked = 1'b0;
      r_next.user_password_length = '0;
      r_next.temporary_write_protect = 1'b0;
      r_next.group_write_protect = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // No wait states: read data is loaded in the setup cycle
  assign prdata_out = r_reg.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_known(paddr_in);
  // Secure area is never requested; the eraser covers user area only
  assign erase_req_out = r_reg.st == CLFE_ERASING;
  assign card_locked_out = r_reg.locked;
  assign lock_fail_flag_out = r_reg.fail;
  assign plain_cmd_valid_out = r_reg.plain_valid;
  assign plain_cmd_mode_out = r_reg.last_mode;

endmodule : clfe_card_lock
`default_nettype wire

// *** hw/clfe_pkg.sv ***
// Shared constants and carrier types for the card lock / force-erase block.
// Assumes one 100 MHz system clock; the link clock is sampled, not used as a clock.
package clfe_pkg;

  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [7:0] CLFE_OFS_CTRL = 8'h00;
  localparam logic [7:0] CLFE_OFS_USER_LEN = 8'h04;
  localparam logic [7:0] CLFE_OFS_STATUS = 8'h08;
  localparam logic [7:0] CLFE_OFS_LAST_MODE = 8'h0C;

  // ****************************************
  // Field positions
  // ****************************************
  // Control register
  localparam int CLFE_CTRL_LOCKED = 0;
  localparam int CLFE_CTRL_PERM_PROT = 1;
  localparam int CLFE_CTRL_TEMP_PROT = 2;
  localparam int CLFE_CTRL_GROUP_PROT = 3;
  localparam int CLFE_CTRL_SOFT_RST = 4;
  // Status register
  localparam int CLFE_ST_LOCKED = 0;
  localparam int CLFE_ST_FAIL = 1;
  localparam int CLFE_ST_UNLOCK_SEEN = 2;
  localparam int CLFE_ST_V2_EN = 3;
  localparam int CLFE_ST_ERASING = 4;
  localparam int CLFE_ST_GUARD = 5;
  localparam int CLFE_ST_GLEN_LSB = 8;

  // ****************************************
  // Lock command mode byte
  // ****************************************
  localparam int CLFE_MODE_ERASE_BIT = 3;
  localparam int CLFE_MODE_OPTION_BIT = 4;
  localparam logic [7:0] CLFE_MODE_OPTION_UNLOCK = 8'h1F;
  localparam logic [7:0] CLFE_MODE_SET_GUARD = 8'h11;
  localparam logic [7:0] CLFE_MODE_CLR_GUARD = 8'h12;
  localparam logic [7:0] CLFE_MODE_PROT_ERASE = 8'h18;
  localparam logic [7:0] CLFE_MODE_FORCE_ERASE = 8'h08;
  // Byte positions inside the lock data block
  localparam int CLFE_POS_MODE = 0;
  localparam int CLFE_POS_SIZE = 1;
  localparam int CLFE_POS_PASSWORD = 2;
  localparam int CLFE_PLAIN_ERASE_BYTES = 1;

  localparam int CLFE_PW_BYTES = 16;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } clfe_byte_s;

  typedef struct packed {
    logic start;
    logic stop;
  } clfe_frame_s;

endpackage : clfe_pkg

// *** hw/clfe_link_rx.sv ***
// Lock data link receiver: frame, clock and data pins to bytes, MSB first.
// Assumes the link clock is far slower than clk_in (80 ns vs 10 ns).
`timescale 1ns/1ps
`default_nettype none
module clfe_link_rx (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Link pins
  input wire logic link_clk_in,
  input wire logic link_frame_in,
  input wire logic link_data_in,
  // Received bytes and frame edges
  output clfe_pkg::clfe_byte_s byte_out,
  output clfe_pkg::clfe_frame_s frame_out
);
  import clfe_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic clk_prev;
    logic frame_prev;
    logic [7:0] shift;
    logic [2:0] bits;
    clfe_byte_s byte_q;
    clfe_frame_s frame_q;
  } clfe_rx_s;

  clfe_rx_s r_reg;
  clfe_rx_s r_next;

  // ****************************************
  // Sampling and deserialising
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.s1 = {link_clk_in, link_frame_in, link_data_in};
    r_next.s2 = r_reg.s1;
    r_next.clk_prev = r_reg.s2[2];
    r_next.frame_prev = r_reg.s2[1];
    r_next.byte_q.valid = 1'b0;
    r_next.frame_q.start = r_reg.s2[1] & ~r_reg.frame_prev;
    r_next.frame_q.stop = ~r_reg.s2[1] & r_reg.frame_prev;
    if (r_next.frame_q.start) begin
      r_next.bits = 3'h0;
    end else if (r_reg.s2[1] && r_reg.s2[2] && !r_reg.clk_prev) begin
      r_next.shift = {r_reg.shift[6:0], r_reg.s2[0]};
      r_next.bits = r_reg.bits + 3'h1;
      // Partial trailing byte is dropped at frame end
      if (r_reg.bits == 3'h7) begin
        r_next.byte_q.valid = 1'b1;
        r_next.byte_q.data = {r_reg.shift[6:0], r_reg.s2[0]};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign byte_out = r_reg.byte_q;
  assign frame_out = r_reg.frame_q;

endmodule : clfe_link_rx
`default_nettype wire

// *** tb/clfe_card_lock_checker.sv ***
// Concurrent checks on the pins of the card lock block.
// Assumes it is bound onto clfe_card_lock; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module clfe_card_lock_checker #(
  parameter int PW_BYTES = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Watched pins
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pslverr_out,
  input wire logic link_frame_in,
  input wire logic erase_req_out,
  input wire logic erase_done_in,
  input wire logic card_locked_out,
  input wire logic lock_fail_flag_out,
  input wire logic plain_cmd_valid_out,
  input wire logic [7:0] plain_cmd_mode_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ****************************************
  // Erase sequencing
  // ****************************************
  a_erase_locked: assert property (erase_req_out |-> card_locked_out)
    else $error("erase running on an unlocked card");
  a_erase_no_fail: assert property ($rose(erase_req_out) |-> !lock_fail_flag_out)
    else $error("erase started with fail flag set");
  a_erase_end_unlock: assert property (erase_req_out && erase_done_in |=>
    !erase_req_out && !card_locked_out && !lock_fail_flag_out)
    else $error("erase end did not unlock the card");
  a_erase_hold: assert property (erase_req_out && !erase_done_in |=> erase_req_out)
    else $error("erase request dropped before done");
  a_erase_after_frame: assert property ($rose(erase_req_out) |-> !$past(link_frame_in, 2))
    else $error("erase began before the block ended");
  // ****************************************
  // Hand-off and bus
  // ****************************************
  a_plain_mode: assert property (plain_cmd_valid_out |->
    !plain_cmd_mode_out[4] && plain_cmd_mode_out != 8'h08)
    else $error("option or erase mode handed off");
  a_plain_pulse: assert property (plain_cmd_valid_out |=> !plain_cmd_valid_out)
    else $error("hand-off pulse longer than one cycle");
  a_slverr_access: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("bus error outside access phase");
  c_erase_done: cover property (erase_req_out && erase_done_in);
  c_plain: cover property (plain_cmd_valid_out);
  c_fail: cover property ($rose(lock_fail_flag_out));
  c_slverr: cover property (pslverr_out);
endmodule : clfe_card_lock_checker

bind clfe_card_lock clfe_card_lock_checker #(.PW_BYTES(PW_BYTES)) u_chk (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pslverr_out(pslverr_out),
  .link_frame_in(link_frame_in),
  .erase_req_out(erase_req_out),
  .erase_done_in(erase_done_in),
  .card_locked_out(card_locked_out),
  .lock_fail_flag_out(lock_fail_flag_out),
  .plain_cmd_valid_out(plain_cmd_valid_out),
  .plain_cmd_mode_out(plain_cmd_mode_out)
);
`default_nettype wire

// *** tb/clfe_host_link.sv ***
// Host model of the lock data link: one data block per call, MSB first.
// Assumes the receiver oversamples the 80 ns link clock with its own clock.
`timescale 1ns/1ps
`default_nettype none
module clfe_host_link (
  // Bench clock the pins are stepped on
  input wire logic clk_in,
  // Link pins
  output logic link_clk_out,
  output logic link_frame_out,
  output logic link_data_out
);
  initial begin
    link_clk_out = 1'b0;
    link_frame_out = 1'b0;
    link_data_out = 1'b1;
  end
  // Clock stands low outside frames; gap lets a slow host be mimicked
  task automatic send(input logic [7:0] b[$], input int gap);
    repeat (gap * 8) @(posedge clk_in);
    link_frame_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        link_data_out <= b[i][k];
        repeat (4) @(posedge clk_in);
        link_clk_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        link_clk_out <= 1'b0;
      end
    end
    repeat (4) @(posedge clk_in);
    link_frame_out <= 1'b0;
    // Released line: no pull, so show the inverse of the last bit
    link_data_out <= ~link_data_out;
    repeat (12) @(posedge clk_in);
  endtask : send
endmodule : clfe_host_link
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench: APB master, host link model, eraser stub.
// Assumes clfe_pkg and the card lock block are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import clfe_pkg::*;
  typedef struct {
    string n;
    logic [32:0] e;
    logic [32:0] m;
  } clfe_note_s;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic erase_done_in = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, erase_req_out, card_locked_out;
  logic lock_fail_flag_out, plain_cmd_valid_out;
  logic [7:0] plain_cmd_mode_out;
  wire logic link_clk_in, link_frame_in, link_data_in;
  clfe_note_s notes[$];
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] g0, g1, h0, h1;

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  clfe_card_lock u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .link_clk_in(link_clk_in), .link_frame_in(link_frame_in), .link_data_in(link_data_in),
    .erase_req_out(erase_req_out), .erase_done_in(erase_done_in),
    .card_locked_out(card_locked_out), .lock_fail_flag_out(lock_fail_flag_out),
    .plain_cmd_valid_out(plain_cmd_valid_out), .plain_cmd_mode_out(plain_cmd_mode_out)
  );
  clfe_host_link u_host (
    .clk_in(clk_in),
    .link_clk_out(link_clk_in),
    .link_frame_out(link_frame_in),
    .link_data_out(link_data_in)
  );

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // ****************************************
  // Result watcher: oldest note against what appears
  // ****************************************
  task automatic take(input logic [32:0] seen);
    clfe_note_s t;
    comparisons++;
    if (notes.size() == 0) begin
      miscompares++;
      $display("[ERR] note queue expected entry seen none");
    end else begin
      t = notes.pop_front();
      if (((seen ^ t.e) & t.m) !== 33'h0) begin
        miscompares++;
        $display("[ERR] %s expected %h seen %h", t.n, t.e & t.m, seen & t.m);
      end
    end
  endtask : take

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (psel_in && penable_in && pready_out && !pwrite_in)
      take({pslverr_out, prdata_out});
    if (plain_cmd_valid_out === 1'b1)
      take({25'h0, plain_cmd_mode_out});
    if (cycles == 30000) begin
      miscompares++;
      stop_test();
    end
  end

  // Results settle four cycles after the block ends; six gives margin
  always @(negedge link_frame_in) begin
    if (rst_b_in) begin
      repeat (6) @(posedge clk_in);
      #1 take({30'h0, erase_req_out, card_locked_out, lock_fail_flag_out});
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input string n = "", input logic [32:0] e = 33'h0,
                     input logic [32:0] m = 33'h0);
    if (!w)
      notes.push_back('{n, e, m});
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  // Expected triple is erase request, locked, fail
  task automatic lnk(input string n, input logic [7:0] b[$], input logic [2:0] e,
                     input logic [2:0] m = 3'h7, input bit plain = 1'b0);
    // Hand-off pulse comes two cycles before the triple is looked at
    if (plain)
      notes.push_back('{"plain_mode", {25'h0, b[0]}, 33'hFF});
    notes.push_back('{n, {30'h0, e}, {30'h0, m}});
    u_host.send(b, $urandom_range(3, 0));
  endtask : lnk

  // Eraser stalls a random while before reporting done
  task automatic finish_erase();
    repeat (8) if (erase_req_out !== 1'b1) @(posedge clk_in);
    repeat ($urandom_range(6, 1)) @(posedge clk_in);
    erase_done_in <= 1'b1;
    @(posedge clk_in);
    erase_done_in <= 1'b0;
  endtask : finish_erase

  initial begin
    void'($urandom(32'hA20A14BF));
    {g0, g1, h0, h1} = $urandom;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    apb(1'b1, CLFE_OFS_STATUS, 32'hFF);
    apb(1'b0, CLFE_OFS_STATUS, 32'h0, "status", 33'h0, ALL);
    apb(1'b0, 8'h10, 32'h0, "unmapped", {1'b1, 32'h0}, ALL);
    apb(1'b1, CLFE_OFS_USER_LEN, 32'h5);
    apb(1'b0, CLFE_OFS_USER_LEN, 32'h0, "user_len", 33'h5, 33'h1F);
    apb(1'b1, CLFE_OFS_CTRL, 32'hE);
    apb(1'b0, CLFE_OFS_CTRL, 32'h0, "ctrl", 33'hE, 33'h1F);
    $display("registers done");
    lnk("erase_unlocked", '{CLFE_MODE_FORCE_ERASE}, 3'b001);
    apb(1'b1, CLFE_OFS_CTRL, 32'hF);
    lnk("erase_pwp", '{CLFE_MODE_FORCE_ERASE}, 3'b011);
    apb(1'b1, CLFE_OFS_CTRL, 32'hD);
    lnk("erase_extra_bit", '{8'h09}, 3'b011);
    lnk("erase_run", '{CLFE_MODE_FORCE_ERASE}, 3'b110);
    finish_erase();
    apb(1'b0, CLFE_OFS_CTRL, 32'h0, "ctrl_after_erase", 33'h0, 33'hF);
    apb(1'b0, CLFE_OFS_USER_LEN, 32'h0, "user_len_erased", 33'h0, 33'h1F);
    $display("force erase done");
    lnk("unlock_no_guard", '{CLFE_MODE_OPTION_UNLOCK}, 3'b000);
    apb(1'b0, CLFE_OFS_STATUS, 32'h0, "v2_enabled", 33'h8, 33'h28);
    lnk("guard_set", '{CLFE_MODE_SET_GUARD, 8'h02, g0, g1}, 3'b000);
    lnk("guard_replace", '{CLFE_MODE_SET_GUARD, 8'h04, g0, g1, h0, h1}, 3'b000);
    apb(1'b0, CLFE_OFS_STATUS, 32'h0, "guard_len", 33'h220, 33'h1F20);
    $display("guard set done");
    apb(1'b1, CLFE_OFS_CTRL, 32'h11);
    lnk("blocked_unlock", '{8'h00}, 3'b011);
    lnk("erase_with_guard", '{CLFE_MODE_FORCE_ERASE}, 3'b011);
    lnk("option_first", '{CLFE_MODE_OPTION_UNLOCK}, 3'b000);
    lnk("option_again", '{CLFE_MODE_OPTION_UNLOCK}, 3'b001);
    lnk("undefined_mode", '{8'h13}, 3'b001);
    apb(1'b0, CLFE_OFS_STATUS, 32'h0, "guard_kept", 33'h220, 33'h1F21);
    $display("option unlock done");
    apb(1'b1, CLFE_OFS_CTRL, 32'h11);
    apb(1'b1, CLFE_OFS_USER_LEN, 32'h4);
    lnk("option_both", '{CLFE_MODE_OPTION_UNLOCK}, 3'b010);
    lnk("user_handoff", '{8'h00}, 3'b010, 3'b111, 1'b1);
    lnk("prot_erase_extra", '{8'h1C, 8'h02, h0, h1}, 3'b011);
    lnk("prot_erase_wrong", '{CLFE_MODE_PROT_ERASE, 8'h02, h0, ~h1}, 3'b011);
    lnk("prot_erase_run", '{CLFE_MODE_PROT_ERASE, 8'h02, h0, h1}, 3'b110);
    finish_erase();
    apb(1'b0, CLFE_OFS_STATUS, 32'h0, "guard_after", 33'h220, 33'h1F21);
    apb(1'b0, CLFE_OFS_USER_LEN, 32'h0, "user_len_gone", 33'h0, 33'h1F);
    lnk("prot_erase_unlocked", '{CLFE_MODE_PROT_ERASE, 8'h02, h0, h1}, 3'b001);
    $display("protected erase done");
    lnk("guard_clear", '{CLFE_MODE_CLR_GUARD, 8'h02, h0, h1}, 3'b000);
    apb(1'b0, CLFE_OFS_STATUS, 32'h0, "guard_gone", 33'h0, 33'h1F21);
    lnk("clear_no_guard", '{CLFE_MODE_CLR_GUARD, 8'h02, h0, h1}, 3'b001);
    $display("guard clear done");
    repeat (10) @(posedge clk_in);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
